// [core/ivcu_pkg.sv]
// Purpose: Constants shared by the indexed variable command unit
// Assumes: Nine-byte command frames delivered one byte per valid cycle
// Notes: Reply status codes other than success are local choices
//
// Behaviour
// RQ1 - Frames carry opcode, type, motor/bank, value in that order; all decoded.
// RQ2 - Opcode 18 writes accumulator to axis parameter numbered by type field.
// RQ3 - Opcode 18 takes its target axis from the index register.
// RQ4 - Opcode 55 writes the frame value into the indexed user variable.
// RQ5 - Store, load and copy do nothing when index is outside 0 to 255.
// RQ6 - Opcode 56 loads the accumulator from the indexed user variable.
// RQ7 - Opcode 57 copies accumulator into indexed variable; accumulator kept.
// RQ8 - Opcodes 64 to 71 are user functions; success replies status 100.
// RQ9 - Host should use these index-based commands mainly in stored programs.
// RQ10 - Value is 32 bits, MSB first, after motor/bank byte, before checksum.
// RQ11 - Checksum is low byte of sum of eight bytes; checked before executing.
package ivcu_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 32;
    localparam int FRAME_LEN = 9;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] POS_LAST = 4'h8;
    localparam logic [CNT_W-1:0] POS_VALUE_LO = 4'h7;
    localparam logic [CNT_W-1:0] POS_ADDR = 4'h0;
    localparam logic [CNT_W-1:0] POS_OPCODE = 4'h1;
    localparam logic [CNT_W-1:0] POS_TYPE = 4'h2;
    localparam logic [CNT_W-1:0] POS_MOTOR = 4'h3;
    localparam logic [CNT_W-1:0] POS_VALUE_HI = 4'h4;
    localparam int VAR_COUNT = 256;
    localparam int VAR_IDX_W = 8;
    localparam int AXIS_W = 8;

    localparam logic [7:0] OP_ACCU_TO_AXIS = 8'h12;
    localparam logic [7:0] OP_STORE_DIRECT = 8'h37;
    localparam logic [7:0] OP_LOAD_VAR = 8'h38;
    localparam logic [7:0] OP_STORE_ACCU = 8'h39;
    localparam logic [7:0] OP_USER_FIRST = 8'h40;
    localparam logic [7:0] OP_USER_LAST = 8'h47;

    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_OPCODE = 8'h02;

    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage

// [core/ivcu_frame_rx.sv]
// Purpose: Assembles nine-byte command frames and checks their checksum
// Assumes: Bytes come from logic on the same clock, one per valid cycle
// Notes: No inter-byte timeout; a lost byte misaligns until reset
`timescale 1ns/1ns
`default_nettype none
module ivcu_frame_rx
    import ivcu_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_byte_valid,
    input wire logic [BYTE_W-1:0] i_byte,
    output logic o_frame_valid,
    output logic o_sum_ok,
    output logic [BYTE_W-1:0] o_addr,
    output logic [BYTE_W-1:0] o_opcode,
    output logic [BYTE_W-1:0] o_type,
    output logic [BYTE_W-1:0] o_motor,
    output logic [WORD_W-1:0] o_value
);
    logic [CNT_W-1:0] pos;
    logic [BYTE_W-1:0] sum;

    function automatic logic [BYTE_W-1:0] add8(input logic [BYTE_W-1:0] a,
                                               input logic [BYTE_W-1:0] b);
        logic [BYTE_W:0] full;
        full = {1'b0, a} + {1'b0, b};
        return full[BYTE_W-1:0];
    endfunction

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pos <= '0;
            sum <= BYTE_ZERO;
        end else if (i_ce && i_byte_valid) begin
            if (pos == POS_LAST) begin
                pos <= '0;
                sum <= BYTE_ZERO;
            end else begin
                pos <= pos + 4'h1;
                sum <= add8(sum, i_byte); // see RQ11
            end
        end
    end

    // Fields in wire order: address, opcode, type, motor, value MSB first
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_addr <= BYTE_ZERO;
            o_opcode <= BYTE_ZERO;
            o_type <= BYTE_ZERO;
            o_motor <= BYTE_ZERO;
            o_value <= WORD_ZERO;
        end else if (i_ce && i_byte_valid) begin
            case (pos)
                POS_ADDR: o_addr <= i_byte;
                POS_OPCODE: o_opcode <= i_byte; // see RQ1
                POS_TYPE: o_type <= i_byte;
                POS_MOTOR: o_motor <= i_byte;
                default: begin
                    if (pos >= POS_VALUE_HI && pos <= POS_VALUE_LO)
                        o_value <= {o_value[WORD_W-BYTE_W-1:0], i_byte}; // see RQ10
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_frame_valid <= 1'b0;
            o_sum_ok <= 1'b0;
        end else if (i_ce) begin
            o_frame_valid <= i_byte_valid && (pos == POS_LAST);
            if (i_byte_valid && (pos == POS_LAST))
                o_sum_ok <= (sum == i_byte); // see RQ11
        end
    end
endmodule // ivcu_frame_rx
`default_nettype wire

// [core/ivcu_core.sv]
// Purpose: Executes indexed axis-parameter and user-variable commands
// Assumes: Index and accumulator are also loaded by other command logic
// Notes: A command's own accumulator load wins over an external load
`timescale 1ns/1ns
`default_nettype none
module ivcu_core
    import ivcu_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [BYTE_W-1:0] i_module_addr,
    input wire logic i_byte_valid,
    input wire logic [BYTE_W-1:0] i_byte,
    input wire logic i_index_load,
    input wire logic [WORD_W-1:0] i_index_value,
    input wire logic i_accu_load,
    input wire logic [WORD_W-1:0] i_accu_value,
    output logic [WORD_W-1:0] o_index,
    output logic [WORD_W-1:0] o_accu,
    output logic o_axis_wr,
    output logic [AXIS_W-1:0] o_axis_num,
    output logic [BYTE_W-1:0] o_axis_param,
    output logic [WORD_W-1:0] o_axis_value,
    output logic o_user_fn,
    output logic [2:0] o_user_fn_num,
    output logic [BYTE_W-1:0] o_user_type,
    output logic [BYTE_W-1:0] o_user_motor,
    output logic [WORD_W-1:0] o_user_value,
    output logic o_reply_valid,
    output logic [BYTE_W-1:0] o_reply_status,
    output logic [BYTE_W-1:0] o_reply_opcode,
    output logic [WORD_W-1:0] o_reply_value
);
    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_EXEC = 3'b010,
        EX_REPLY = 3'b100
    } ivcu_state_t;

    ivcu_state_t state;
    logic frame_valid;
    logic sum_ok;
    logic [BYTE_W-1:0] f_addr;
    logic [BYTE_W-1:0] f_opcode;
    logic [BYTE_W-1:0] f_type;
    logic [BYTE_W-1:0] f_motor;
    logic [WORD_W-1:0] f_value;
    logic [BYTE_W-1:0] c_opcode;
    logic [BYTE_W-1:0] c_type;
    logic [BYTE_W-1:0] c_motor;
    logic [WORD_W-1:0] c_value;
    logic c_sum_ok;
    logic [WORD_W-1:0] user_var [VAR_COUNT];
    logic run;
    logic idx_ok;
    logic [VAR_IDX_W-1:0] idx;

    // ****************************************
    // Helpers
    // ****************************************
    // Index is signed; negative values have bit 31 set and fail here too
    function automatic logic index_in_range(input logic [WORD_W-1:0] x);
        return x[WORD_W-1:VAR_IDX_W] == 24'h00_0000;
    endfunction

    function automatic logic is_user_fn(input logic [BYTE_W-1:0] op);
        return (op >= OP_USER_FIRST) && (op <= OP_USER_LAST);
    endfunction

    function automatic logic is_var_cmd(input logic [BYTE_W-1:0] op);
        return (op == OP_STORE_DIRECT) || (op == OP_LOAD_VAR) || (op == OP_STORE_ACCU);
    endfunction

    ivcu_frame_rx u_frame_rx (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_byte_valid(i_byte_valid),
        .i_byte(i_byte),
        .o_frame_valid(frame_valid),
        .o_sum_ok(sum_ok),
        .o_addr(f_addr),
        .o_opcode(f_opcode),
        .o_type(f_type),
        .o_motor(f_motor),
        .o_value(f_value)
    );

    assign run = i_ce && (state == EX_EXEC) && c_sum_ok; // see RQ11
    assign idx_ok = index_in_range(o_index);
    assign idx = o_index[VAR_IDX_W-1:0];
    assign o_reply_valid = (state == EX_REPLY);

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= EX_IDLE;
        end else if (i_ce) begin
            case (state)
                EX_IDLE: if (frame_valid && f_addr == i_module_addr) state <= EX_EXEC;
                EX_EXEC: state <= EX_REPLY;
                EX_REPLY: state <= EX_IDLE;
                default: state <= EX_IDLE;
            endcase
        end
    end

    // Command fields held for the whole execution
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            c_opcode <= BYTE_ZERO;
            c_type <= BYTE_ZERO;
            c_motor <= BYTE_ZERO;
            c_value <= WORD_ZERO;
            c_sum_ok <= 1'b0;
        end else if (i_ce && state == EX_IDLE && frame_valid) begin
            c_opcode <= f_opcode; // see RQ1
            c_type <= f_type;
            c_motor <= f_motor;
            c_value <= f_value;
            c_sum_ok <= sum_ok;
        end
    end

    // ****************************************
    // Index and accumulator
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_index <= WORD_ZERO;
        end else if (i_ce && i_index_load) begin
            o_index <= i_index_value;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_accu <= WORD_ZERO;
        end else if (i_ce) begin
            if (run && c_opcode == OP_LOAD_VAR && idx_ok)
                o_accu <= user_var[idx]; // see RQ6
            else if (i_accu_load)
                o_accu <= i_accu_value;
        end
    end

    // ****************************************
    // User variables
    // ****************************************
    // Flop storage keeps reset defined; costs area over a RAM macro
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < VAR_COUNT; i++) user_var[i] <= WORD_ZERO;
        end else if (run && idx_ok) begin // see RQ5
            if (c_opcode == OP_STORE_DIRECT)
                user_var[idx] <= c_value; // see RQ4
            else if (c_opcode == OP_STORE_ACCU)
                user_var[idx] <= o_accu; // see RQ7
        end
    end

    // ****************************************
    // Axis parameter and user function strobes
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_axis_wr <= 1'b0;
            o_axis_num <= BYTE_ZERO;
            o_axis_param <= BYTE_ZERO;
            o_axis_value <= WORD_ZERO;
        end else if (i_ce) begin
            o_axis_wr <= run && c_opcode == OP_ACCU_TO_AXIS; // see RQ2
            if (run && c_opcode == OP_ACCU_TO_AXIS) begin
                o_axis_num <= o_index[AXIS_W-1:0]; // see RQ3
                o_axis_param <= c_type; // see RQ2
                o_axis_value <= o_accu;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_user_fn <= 1'b0;
            o_user_fn_num <= 3'h0;
            o_user_type <= BYTE_ZERO;
            o_user_motor <= BYTE_ZERO;
            o_user_value <= WORD_ZERO;
        end else if (i_ce) begin
            o_user_fn <= run && is_user_fn(c_opcode); // see RQ8
            if (run && is_user_fn(c_opcode)) begin
                o_user_fn_num <= c_opcode[2:0];
                o_user_type <= c_type;
                o_user_motor <= c_motor;
                o_user_value <= c_value;
            end
        end
    end

    // ****************************************
    // Reply
    // ****************************************
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reply_status <= BYTE_ZERO;
            o_reply_opcode <= BYTE_ZERO;
            o_reply_value <= WORD_ZERO;
        end else if (i_ce && state == EX_EXEC) begin
            o_reply_opcode <= c_opcode;
            o_reply_value <= (run && c_opcode == OP_LOAD_VAR && idx_ok) ? user_var[idx]
                                                                       : WORD_ZERO;
            if (!c_sum_ok)
                o_reply_status <= STATUS_BAD_SUM; // see RQ11
            else if (c_opcode == OP_ACCU_TO_AXIS || is_var_cmd(c_opcode) ||
                     is_user_fn(c_opcode))
                o_reply_status <= STATUS_OK; // see RQ8
            else
                o_reply_status <= STATUS_BAD_OPCODE;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_store_direct_var: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ4
        run && c_opcode == OP_STORE_DIRECT && idx_ok |=> user_var[$past(idx)] == $past(c_value))
        else $error("Direct value not stored in indexed variable");

    a_load_var_accu: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ6
        run && c_opcode == OP_LOAD_VAR && idx_ok |=> o_accu == $past(user_var[idx]))
        else $error("Accumulator not loaded from indexed variable");

    a_store_accu_var: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ7
        run && c_opcode == OP_STORE_ACCU && idx_ok && !i_accu_load
        |=> user_var[$past(idx)] == $past(o_accu) && $stable(o_accu))
        else $error("Accumulator copy wrong or accumulator disturbed");

    a_bad_index_noop: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ5
        run && is_var_cmd(c_opcode) && !idx_ok && !i_accu_load
        |=> user_var[$past(idx)] == $past(user_var[idx]) && $stable(o_accu))
        else $error("Out-of-range index changed state");

    a_axis_write_target: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ3
        run && c_opcode == OP_ACCU_TO_AXIS
        |=> o_axis_wr && o_axis_num == $past(o_index[AXIS_W-1:0])
        && o_axis_param == $past(c_type) && o_axis_value == $past(o_accu))
        else $error("Axis parameter write wrong");

    a_frame_to_reply: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ11
        state == EX_IDLE && frame_valid && f_addr == i_module_addr && !sum_ok
        |=> !o_reply_valid ##1 o_reply_valid && o_reply_status == STATUS_BAD_SUM && !o_axis_wr)
        else $error("Bad checksum not refused");

    a_user_fn_ok: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ8
        run && is_user_fn(c_opcode)
        |=> o_user_fn && o_reply_valid && o_reply_status == STATUS_OK)
        else $error("User function not acknowledged with success");

    a_foreign_addr_quiet: assert property (@(posedge i_mclk) disable iff (!i_resetn || !i_ce) // see RQ1
        state == EX_IDLE && frame_valid && f_addr != i_module_addr |=> ##1 !o_reply_valid)
        else $error("Reply given to frame for another address");
endmodule // ivcu_core
`default_nettype wire

// [testbench/ivcu_host.sv]
// Purpose: Host model that sends nine-byte command frames
// Assumes: One byte per clock, queued frames go out back to back
// Notes: Idle byte line toggles so stale data is never mistaken for a byte
`timescale 1ns/1ns
`default_nettype none
module ivcu_host
    import ivcu_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    output logic o_byte_valid,
    output logic [BYTE_W-1:0] o_byte
);
    logic [BYTE_W-1:0] pend[$];

    // ********************
    // Frame building
    // ********************
    // Index-based commands come from a stored program in practice; sent direct here
    task automatic send(input logic [7:0] addr, op, typ, mot, input logic [31:0] val,
                        input logic corrupt);
        logic [7:0] f[9];
        f = '{addr, op, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++) f[8] += f[i];
        f[8] = f[8] ^ {7'h00, corrupt};
        foreach (f[i]) pend.push_back(f[i]);
    endtask

    // ********************
    // Byte stream
    // ********************
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_byte_valid <= 1'b0;
            o_byte <= 8'h00;
        end else if (pend.size() != 0) begin
            o_byte_valid <= 1'b1;
            o_byte <= pend.pop_front();
        end else begin
            o_byte_valid <= 1'b0;
            o_byte <= ~o_byte;
        end
    end
endmodule // ivcu_host
`default_nettype wire

// [testbench/indexed_variable_command_unit_tb.sv]
// Purpose: Self-checking bench for the indexed variable command unit
// Assumes: Bench keeps its own index, accumulator and variable model
// Notes: Loads happen only while no frame is pending, so the model stays exact
`timescale 1ns/1ns
`default_nettype none
module indexed_variable_command_unit_tb
    import ivcu_pkg::*;
;
    localparam logic [7:0] MY_ADDR = 8'h01;
    typedef struct {
        logic [7:0] status, opcode, num, param, motor;
        logic [31:0] value, aval;
        logic axis, ufn;
    } ivcu_exp_t;

    logic i_mclk = 1'b0, i_resetn, i_ce, i_byte_valid, i_index_load, i_accu_load;
    logic [7:0] i_module_addr, i_byte;
    logic [31:0] i_index_value, i_accu_value, o_index, o_accu, o_axis_value, o_user_value;
    logic [31:0] o_reply_value, idx, accu, seed = 32'h2709, vars[256];
    logic o_axis_wr, o_user_fn, o_reply_valid;
    logic [7:0] o_axis_num, o_axis_param, o_user_type, o_user_motor, o_reply_status;
    logic [7:0] o_reply_opcode;
    logic [2:0] o_user_fn_num;
    int bad_count = 0, num_checks = 0, cycles = 0;
    ivcu_exp_t exp_q[$], m;
    logic [7:0] bad_ops[6] = '{8'h11, 8'h13, 8'h36, 8'h3a, 8'h3f, 8'h48};

    ivcu_host u_host (.i_mclk(i_mclk), .i_resetn(i_resetn), .o_byte_valid(i_byte_valid),
        .o_byte(i_byte));
    ivcu_core DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_module_addr(i_module_addr), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
        .i_index_load(i_index_load), .i_index_value(i_index_value), .i_accu_load(i_accu_load),
        .i_accu_value(i_accu_value), .o_index(o_index), .o_accu(o_accu), .o_axis_wr(o_axis_wr),
        .o_axis_num(o_axis_num), .o_axis_param(o_axis_param), .o_axis_value(o_axis_value),
        .o_user_fn(o_user_fn), .o_user_fn_num(o_user_fn_num), .o_user_type(o_user_type),
        .o_user_motor(o_user_motor), .o_user_value(o_user_value),
        .o_reply_valid(o_reply_valid), .o_reply_status(o_reply_status),
        .o_reply_opcode(o_reply_opcode), .o_reply_value(o_reply_value));

    always #50 i_mclk = ~i_mclk;

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Sel 0 loads the index, sel 1 the accumulator
    task automatic load(input logic sel, input logic [31:0] v);
        @(posedge i_mclk);
        if (sel) begin
            i_accu_load <= 1'b1;
            i_accu_value <= v;
            accu = v;
        end else begin
            i_index_load <= 1'b1;
            i_index_value <= v;
            idx = v;
        end
        @(posedge i_mclk);
        i_accu_load <= 1'b0;
        i_index_load <= 1'b0;
    endtask

    task automatic cmd(input logic [7:0] addr, op, typ, input logic [31:0] val, input logic bad);
        logic ok;
        logic [7:0] mot;
        ok = (idx < 32'd256);
        mot = 8'(rnd() >> 24);
        m = '{status: STATUS_OK, opcode: op, num: idx[7:0], param: typ, motor: mot,
              value: WORD_ZERO, aval: accu, axis: 1'b0, ufn: 1'b0};
        if (bad) m.status = STATUS_BAD_SUM;
        else if (op == OP_ACCU_TO_AXIS) m.axis = 1'b1;
        else if (op == OP_STORE_DIRECT && ok && addr == MY_ADDR) vars[idx[7:0]] = val;
        else if (op == OP_LOAD_VAR && ok) begin
            m.value = vars[idx[7:0]];
            accu = m.value;
        end else if (op == OP_STORE_ACCU && ok) vars[idx[7:0]] = accu;
        else if (op >= OP_USER_FIRST && op <= OP_USER_LAST) begin
            m.ufn = 1'b1;
            m.num = op - OP_USER_FIRST;
            m.aval = val;
        end else if (!(op inside {OP_STORE_DIRECT, OP_LOAD_VAR, OP_STORE_ACCU}))
            m.status = STATUS_BAD_OPCODE;
        if (addr == MY_ADDR) exp_q.push_back(m);
        u_host.send(addr, op, typ, mot, val, bad);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((u_host.pend.size() != 0 || exp_q.size() != 0) && n < 300) begin
            @(negedge i_mclk);
            n++;
        end
        repeat (4) @(negedge i_mclk);
        check(n < 300, 1'b1);
    endtask

    // ********************
    // Reply monitor
    // ********************
    always @(negedge i_mclk) begin
        if (i_resetn === 1'b1 && o_reply_valid === 1'b1) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else begin
                m = exp_q.pop_front();
                check(o_reply_status, m.status);
                check(o_reply_opcode, m.opcode);
                check(o_reply_value, m.value);
                check(o_axis_wr, m.axis);
                check(o_user_fn, m.ufn);
                if (m.axis) check({o_axis_num, o_axis_param}, {m.num, m.param});
                if (m.axis) check(o_axis_value, m.aval);
                if (m.ufn) check({o_user_fn_num, o_user_type, o_user_motor},
                                 {m.num[2:0], m.param, m.motor});
                if (m.ufn) check(o_user_value, m.aval);
            end
        end
    end

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        {i_resetn, i_index_load, i_accu_load, i_index_value, i_accu_value} = '0;
        i_ce = 1'b1;
        i_module_addr = MY_ADDR;
        {idx, accu} = '0;
        foreach (vars[i]) vars[i] = WORD_ZERO;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        // Out-of-range index leaves variables and accumulator alone
        // Drain before each index load, else queued frames run with the new index
        for (int k = 0; k < 2; k++) begin
            load(1'b0, k ? 32'hffff_ffff : 32'd256);
            cmd(MY_ADDR, OP_STORE_DIRECT, 8'h00, rnd(), 1'b0);
            cmd(MY_ADDR, OP_STORE_ACCU, 8'h00, rnd(), 1'b0);
            cmd(MY_ADDR, OP_LOAD_VAR, 8'h00, rnd(), 1'b0);
            drain();
            check(o_accu, accu);
        end
        load(1'b0, 32'd0);
        cmd(MY_ADDR, OP_LOAD_VAR, 8'h00, rnd(), 1'b0);
        drain();
        for (int k = 0; k < 6; k++) begin
            load(1'b0, k == 0 ? 32'd0 : k == 1 ? 32'd255 : rnd() & 32'hff);
            cmd(MY_ADDR, OP_STORE_DIRECT, 8'h00, rnd(), 1'b0);
            cmd(MY_ADDR, OP_LOAD_VAR, 8'h00, rnd(), 1'b0);
            drain();
            check(o_accu, accu);
            check(o_index, idx);
            load(1'b1, rnd());
            cmd(MY_ADDR, OP_STORE_ACCU, 8'h00, rnd(), 1'b0);
            drain();
            check(o_accu, accu);
            cmd(MY_ADDR, OP_LOAD_VAR, 8'h00, rnd(), 1'b0);
            cmd(MY_ADDR, OP_STORE_DIRECT, 8'h00, rnd(), 1'b1);
            cmd(8'h02, OP_STORE_DIRECT, 8'h00, rnd(), 1'b0);
            cmd(MY_ADDR, OP_LOAD_VAR, 8'h00, rnd(), 1'b0);
            drain();
            load(1'b1, rnd());
            cmd(MY_ADDR, OP_ACCU_TO_AXIS, rnd() >> 24, rnd(), 1'b0);
            drain();
        end
        // Enable low must freeze the index even with a load request present
        @(posedge i_mclk);
        i_ce <= 1'b0;
        i_index_load <= 1'b1;
        i_index_value <= rnd();
        @(posedge i_mclk);
        i_ce <= 1'b1;
        i_index_load <= 1'b0;
        @(negedge i_mclk);
        check(o_index, idx);
        for (int op = 64; op <= 71; op++) cmd(MY_ADDR, op, rnd() >> 24, rnd(), 1'b0);
        foreach (bad_ops[k])
            cmd(MY_ADDR, bad_ops[k], 8'h00, rnd(), 1'b0);
        drain();
        final_report();
    end
endmodule // indexed_variable_command_unit_tb
`default_nettype wire
